// File: verilog/lpe_top.sv
// Purpose: longword parity generate/check and fill parity error capture
// Assumes: all inputs synchronous to aclk; registers over axi4-lite
// Notes: one-cycle event pulses capture state; status cleared by software
//
// Notes on behaviour
// - expansion writes into memory get one parity bit per longword
// - expansion reads of memory checked for longword parity before bus
// - host parity error drives the parity input, then nmi request line
// - host parity error sets system parity error flag in nmi csr
// - processor memory reads return stored parity alongside data, checked
// - fill parity error classed instruction or data stream by fill kind
// - instruction fill error: data written unchanged, block marked valid
// - both fill error kinds raise machine check
// - fill error sets data parity flag; instruction read flag by kind
// - fill address bits 33..5 and quadword field record bad address
// - syndrome register shows which longwords failed parity
// - error address register and status bits 6..0 locked on fill error
// - instruction fill error locks data cache status register
// - cache tag register keeps tag probe result when cache enabled
// - data fill error: data written unchanged, block marked valid
// - data fill error only: fill address bits 4..2 take load physical address bits 4..2
// - destination register field names register receiving bad data
// - load type fields identify kind of failing load
`timescale 1ns/1ns
module lpe_top #(
  parameter int LONGWORDS = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // expansion write path into memory
  input wire logic exp_wr_valid,
  input wire logic [31:0] exp_wr_data,
  output logic mem_wr_valid,
  output logic [31:0] mem_wr_data,
  output logic mem_wr_parity,
  // expansion read path from memory
  input wire logic exp_rd_valid,
  input wire logic [31:0] exp_rd_data,
  input wire logic exp_rd_parity,
  output logic exp_bus_valid,
  output logic [31:0] exp_bus_data,
  output logic nmi_request_line,
  // processor fill from memory
  input wire logic fill_valid,
  input wire logic fill_instr,
  input wire logic [LONGWORDS*32-1:0] fill_data,
  input wire logic [LONGWORDS-1:0] fill_parity,
  input wire logic [33:2] fill_pa,
  input wire logic [1:0] fill_quadword_field,
  input wire logic [4:0] load_dest_reg,
  input wire logic load_longword,
  input wire logic load_locked,
  input wire logic load_integer,
  input wire logic load_legacy_float,
  input wire logic ext_cache_enabled,
  input wire logic [31:0] tag_probe_result,
  output logic cache_wr_valid,
  output logic cache_wr_icache,
  output logic [LONGWORDS*32-1:0] cache_wr_data,
  output logic cache_block_valid,
  output logic machine_check,
  output logic irq
);
  import lpe_pkg::*;

  if (LONGWORDS < 1 || LONGWORDS > 32) begin : g_bad_words
    $error("LONGWORDS must be 1..32");
  end

  // ==========================================
  // parity generate and check
  logic [LONGWORDS-1:0] word_bad;
  logic fill_err;
  logic host_err;
  logic check_en;
  genvar g;
  generate
    for (g = 0; g < LONGWORDS; g++) begin : g_word
      assign word_bad[g] = (^fill_data[g*32 +: 32]) ^ fill_parity[g];
    end
  endgenerate
  assign fill_err = fill_valid && check_en && (|word_bad);
  assign host_err = exp_rd_valid && check_en && ((^exp_rd_data) ^ exp_rd_parity);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_wr_valid <= 1'b0;
      mem_wr_data <= RESET_WORD;
      mem_wr_parity <= 1'b0;
    end else begin
      mem_wr_valid <= exp_wr_valid;
      mem_wr_data <= exp_wr_data;
      mem_wr_parity <= ^exp_wr_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exp_bus_valid <= 1'b0;
      exp_bus_data <= RESET_WORD;
    end else begin
      exp_bus_valid <= exp_rd_valid;
      exp_bus_data <= exp_rd_data;
    end
  end

  // fill data always goes into the cache unmodified, block validated
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cache_wr_valid <= 1'b0;
      cache_wr_icache <= 1'b0;
      cache_wr_data <= '0;
      cache_block_valid <= 1'b0;
      machine_check <= 1'b0;
    end else begin
      cache_wr_valid <= fill_valid;
      cache_wr_icache <= fill_instr;
      cache_wr_data <= fill_data;
      cache_block_valid <= fill_valid;
      machine_check <= fill_err;
    end
  end

  // ==========================================
  // error capture registers
  logic nmi_flag_q;
  logic dperr_q;
  logic ird_q;
  logic [1:0] qw_q;
  logic [6:0] bs_low_q;
  logic locked_q;
  logic [31:0] err_addr_q;
  logic [33:2] fill_addr_q;
  logic [LONGWORDS-1:0] syn_q;
  logic [8:0] data_cache_status_q;
  logic dc_locked_q;
  logic [31:0] tag_q;
  logic [1:0] irq_stat_q;
  logic [1:0] irq_en_q;
  logic ctrl_q;
  logic wr_fire;
  logic [7:0] wr_addr_q;
  logic [31:0] wr_data_q;
  logic [3:0] wr_strb_q;
  logic nmi_clr;
  logic bs_clr;
  logic [1:0] irq_clr;

  assign check_en = ctrl_q;
  assign nmi_request_line = nmi_flag_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nmi_flag_q <= 1'b0;
    end else if (host_err) begin
      nmi_flag_q <= 1'b1;
    end else if (nmi_clr) begin
      nmi_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dperr_q <= 1'b0;
      ird_q <= 1'b0;
      qw_q <= 2'h0;
      fill_addr_q <= '0;
      syn_q <= '0;
    end else if (fill_err) begin
      dperr_q <= 1'b1;
      ird_q <= fill_instr;
      qw_q <= fill_quadword_field;
      fill_addr_q[33:5] <= fill_pa[33:5];
      if (!fill_instr) begin
        fill_addr_q[4:2] <= fill_pa[4:2];
      end
      syn_q <= word_bad;
    end else if (bs_clr) begin
      dperr_q <= 1'b0;
      ird_q <= 1'b0;
    end
  end

  // address register and low status bits freeze while an error is held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      locked_q <= 1'b0;
      err_addr_q <= RESET_WORD;
      bs_low_q <= 7'h00;
    end else if (fill_err) begin
      locked_q <= 1'b1;
    end else if (bs_clr) begin
      locked_q <= 1'b0;
    end else if (!locked_q && fill_valid) begin
      err_addr_q <= fill_pa[33:2];
      bs_low_q <= {fill_instr, fill_quadword_field, 4'h0};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_cache_status_q <= 9'h000;
      dc_locked_q <= 1'b0;
    end else if (fill_err && fill_instr) begin
      dc_locked_q <= 1'b1;
    end else if (fill_err && !dc_locked_q) begin
      data_cache_status_q[4:0] <= load_dest_reg;
      data_cache_status_q[DC_LONG_BIT] <= load_longword;
      data_cache_status_q[DC_LOCK_BIT] <= load_locked;
      data_cache_status_q[DC_INT_BIT] <= load_integer;
      data_cache_status_q[DC_LEGACY_FP_BIT] <= load_legacy_float;
    end else if (bs_clr) begin
      dc_locked_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tag_q <= RESET_WORD;
    end else if (fill_err && ext_cache_enabled) begin
      tag_q <= tag_probe_result;
    end
  end

  // sticky interrupt status, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_q <= 2'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | {fill_err, host_err};
    end
  end
  assign irq = |(irq_stat_q & irq_en_q);

  // ==========================================
  // axi4-lite write channel
  logic aw_held_q;
  logic w_held_q;
  logic bad_wr;
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready = !w_held_q && !s_axi_bvalid;
  assign wr_fire = (aw_held_q || (s_axi_awvalid && s_axi_awready)) &&
                   (w_held_q || (s_axi_wvalid && s_axi_wready));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= RESET_WORD;
      wr_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        wr_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wr_data_q <= s_axi_wdata;
        wr_strb_q <= s_axi_wstrb;
      end
      aw_held_q <= wr_fire ? 1'b0 : (aw_held_q || (s_axi_awvalid && s_axi_awready));
      w_held_q <= wr_fire ? 1'b0 : (w_held_q || (s_axi_wvalid && s_axi_wready));
    end
  end

  logic [7:0] wa;
  logic [31:0] wd;
  logic [3:0] ws;
  assign wa = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : wr_addr_q;
  assign ws = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wr_strb_q;
  // byte lanes without a strobe read as zero
  assign wd = ((s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wr_data_q) &
              {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  assign nmi_clr = wr_fire && wa == OFF_NMI_CSR && wd[NMI_PARITY_BIT];
  assign bs_clr = wr_fire && wa == OFF_BUS_STAT && wd[BS_DATA_ERR_BIT];
  assign irq_clr = (wr_fire && wa == OFF_IRQ_CLR) ? wd[1:0] : 2'h0;
  assign bad_wr = !(wa == OFF_NMI_CSR || wa == OFF_BUS_STAT || wa == OFF_IRQ_EN ||
                    wa == OFF_IRQ_CLR || wa == OFF_CTRL);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_en_q <= 2'h0;
      ctrl_q <= CTRL_RESET[CTRL_CHECK_EN];
    end else if (wr_fire) begin
      if (wa == OFF_IRQ_EN) begin
        irq_en_q <= wd[1:0];
      end
      if (wa == OFF_CTRL) begin
        ctrl_q <= wd[CTRL_CHECK_EN];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= bad_wr ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================
  // axi4-lite read channel
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_mux = RESET_WORD;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      OFF_NMI_CSR: rd_mux[NMI_PARITY_BIT] = nmi_flag_q;
      OFF_BUS_STAT: rd_mux[12:0] = {locked_q, qw_q, ird_q, dperr_q, 1'b0, bs_low_q};
      OFF_ERR_ADDR: rd_mux = err_addr_q;
      OFF_FILL_ADDR_LO: rd_mux = {fill_addr_q[31:2], 2'h0};
      OFF_FILL_ADDR_HI: rd_mux[1:0] = fill_addr_q[33:32];
      OFF_SYNDROME: rd_mux[LONGWORDS-1:0] = syn_q;
      OFF_DCACHE_STAT: rd_mux[8:0] = data_cache_status_q;
      OFF_TAG: rd_mux = tag_q;
      OFF_IRQ_STAT: rd_mux[1:0] = irq_stat_q;
      OFF_IRQ_EN: rd_mux[1:0] = irq_en_q;
      OFF_CTRL: rd_mux[0] = ctrl_q;
      default: rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RESET_WORD;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================
  // checks
  host_nmi_a: assert property (@(posedge aclk) disable iff (!aresetn)
    host_err |=> nmi_request_line)
    else $error("host parity error did not raise nmi");
  nmi_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    host_err |=> nmi_flag_q && irq_stat_q[IRQ_HOST_PAR])
    else $error("parity flag not set");
  wr_parity_a: assert property (@(posedge aclk) disable iff (!aresetn)
    exp_wr_valid |=> mem_wr_valid && (mem_wr_parity == ^mem_wr_data))
    else $error("write parity wrong");
  mcheck_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fill_err |=> machine_check && dperr_q)
    else $error("fill error missed machine check");
  ird_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fill_err |=> ird_q == $past(fill_instr))
    else $error("instruction read flag wrong");
  syndrome_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fill_err |=> syn_q == $past(word_bad) && syn_q != '0)
    else $error("syndrome wrong");
  fill_unmod_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fill_valid |=> cache_block_valid && cache_wr_data == $past(fill_data))
    else $error("fill data altered");
  lock_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    locked_q && !bs_clr |=> $stable(err_addr_q) && $stable(bs_low_q))
    else $error("locked registers changed");
  dc_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fill_err && fill_instr |=> dc_locked_q)
    else $error("data cache status not locked");
  tag_keep_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fill_err && ext_cache_enabled |=> tag_q == $past(tag_probe_result))
    else $error("tag probe not kept");
endmodule

// File: verilog/lpe_pkg.sv
// Purpose: constants for longword parity error capture block
// Assumes: 32-bit axi4-lite register bus, 100 MHz aclk
// Notes: offsets are byte addresses
package lpe_pkg;
  // ==========================================
  // register offsets
  localparam logic [7:0] OFF_NMI_CSR = 8'h00;
  localparam logic [7:0] OFF_BUS_STAT = 8'h04;
  localparam logic [7:0] OFF_ERR_ADDR = 8'h08;
  localparam logic [7:0] OFF_FILL_ADDR_LO = 8'h0C;
  localparam logic [7:0] OFF_FILL_ADDR_HI = 8'h10;
  localparam logic [7:0] OFF_SYNDROME = 8'h14;
  localparam logic [7:0] OFF_DCACHE_STAT = 8'h18;
  localparam logic [7:0] OFF_TAG = 8'h1C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFF_IRQ_EN = 8'h24;
  localparam logic [7:0] OFF_IRQ_CLR = 8'h28;
  localparam logic [7:0] OFF_CTRL = 8'h2C;
  // ==========================================
  // field positions
  localparam int NMI_PARITY_BIT = 7;
  localparam int BS_DATA_ERR_BIT = 8;
  localparam int BS_INSTR_READ_BIT = 9;
  localparam int BS_QUAD_LSB = 10;
  localparam int BS_LOCK_BIT = 12;
  localparam int DC_DEST_LSB = 0;
  localparam int DC_LONG_BIT = 5;
  localparam int DC_LOCK_BIT = 6;
  localparam int DC_INT_BIT = 7;
  localparam int DC_LEGACY_FP_BIT = 8;
  localparam int IRQ_HOST_PAR = 0;
  localparam int IRQ_FILL_PAR = 1;
  localparam int CTRL_CHECK_EN = 0;
  // ==========================================
  // reset values and answers
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: bench/lpe_mem_model.sv
// Purpose: memory and expansion device model for lpe_top
// Assumes: one stored word is enough for the bench
// Notes: rd_bad flips the returned parity bit on command
`timescale 1ns/1ns
module lpe_mem_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic mem_wr_valid,
  input wire logic [31:0] mem_wr_data,
  input wire logic mem_wr_parity,
  input wire logic rd_req,
  input wire logic rd_bad,
  output logic exp_rd_valid,
  output logic [31:0] exp_rd_data,
  output logic exp_rd_parity
);
  logic [31:0] mem_q;
  logic par_q;
  // ======
  // stored word keeps the parity the block made
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mem_q <= 32'h0000_0000;
      par_q <= 1'b0;
    end else if (mem_wr_valid) begin
      mem_q <= mem_wr_data;
      par_q <= mem_wr_parity;
    end
  end
  // idle bus shows the inverse, never a stale copy
  assign exp_rd_valid = rd_req;
  assign exp_rd_data = rd_req ? mem_q : ~mem_q;
  assign exp_rd_parity = rd_req ? (par_q ^ rd_bad) : ~par_q;
endmodule

// File: bench/lpe_top_tb.sv
// Purpose: self-checking bench for lpe_top
// Assumes: lpe_mem_model stands for memory and expansion devices
// Notes: registers reached through axi4-lite tasks
`timescale 1ns/1ns
module lpe_top_tb;
  import lpe_pkg::*;
  localparam int NWD = 8;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ewv, mwv, mwp, erv, erp, ebv, nmi, rq, rb;
  logic fv, fi, ext_en, ld_long, ld_lock, ld_int, ld_fp, cwv, cwi, cwb, mck, irq;
  logic chk_on;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, ewd, mwd, erd, ebd, tag, rd, sv_st, sv_ad;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp, fqw, wsp;
  logic [NWD*32-1:0] fd, cwd;
  logic [NWD-1:0] fp;
  logic [33:2] pa;
  logic [4:0] ld_dest;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  lpe_top #(.LONGWORDS(NWD)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .exp_wr_valid(ewv), .exp_wr_data(ewd), .mem_wr_valid(mwv), .mem_wr_data(mwd),
    .mem_wr_parity(mwp), .exp_rd_valid(erv), .exp_rd_data(erd), .exp_rd_parity(erp),
    .exp_bus_valid(ebv), .exp_bus_data(ebd), .nmi_request_line(nmi), .fill_valid(fv),
    .fill_instr(fi), .fill_data(fd), .fill_parity(fp), .fill_pa(pa), .fill_quadword_field(fqw),
    .load_dest_reg(ld_dest), .load_longword(ld_long), .load_locked(ld_lock),
    .load_integer(ld_int), .load_legacy_float(ld_fp), .ext_cache_enabled(ext_en),
    .tag_probe_result(tag), .cache_wr_valid(cwv), .cache_wr_icache(cwi),
    .cache_wr_data(cwd), .cache_block_valid(cwb), .machine_check(mck), .irq(irq)
  );
  lpe_mem_model mem_u (
    .aclk(aclk), .aresetn(aresetn), .mem_wr_valid(mwv), .mem_wr_data(mwd),
    .mem_wr_parity(mwp), .rd_req(rq), .rd_bad(rb), .exp_rd_valid(erv),
    .exp_rd_data(erd), .exp_rd_parity(erp)
  );
  // ======
  // clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      complete_run;
    end
  end
  // ======
  // tasks
  task automatic complete_run;
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        wsp = bresp;
        done = 1'b1;
      end
    end
    #1;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        rd = rdata;
        rsp = rresp;
        done = 1'b1;
      end
    end
  endtask
  task automatic host_rd(input logic bad);
    @(posedge aclk);
    rq <= 1'b1;
    rb <= bad;
    @(posedge aclk);
    rq <= 1'b0;
    #1;
    chk({31'h0, ebv}, 32'h0000_0001);
    chk(ebd, ewd);
    repeat (2) @(posedge aclk);
    #1;
    chk({31'h0, nmi}, {31'h0, bad && chk_on});
  endtask
  task automatic do_fill(input logic ins, input logic [NWD-1:0] bad, input logic [33:2] a);
    logic [NWD*32-1:0] d;
    logic [NWD-1:0] p;
    for (int i = 0; i < NWD; i++) begin
      d[i*32 +: 32] = 32'h1357_9BDF + 32'(i);
      p[i] = (^d[i*32 +: 32]) ^ bad[i];
    end
    @(posedge aclk);
    fv <= 1'b1;
    fi <= ins;
    fd <= d;
    fp <= p;
    pa <= a;
    @(posedge aclk);
    fv <= 1'b0;
    #1;
    chk({29'h0, cwv, cwb, cwd === d}, 32'h0000_0007);
    chk({31'h0, cwi}, {31'h0, ins});
    chk({31'h0, mck}, {31'h0, |bad});
  endtask
  task automatic chk_capture(input logic ins, input logic [NWD-1:0] bad, input logic [33:2] a);
    axi_rd(OFF_BUS_STAT);
    chk({27'h0, rd[12:8]}, {27'h0, 1'b1, fqw, ins, 1'b1});
    axi_rd(OFF_SYNDROME);
    chk(rd, {24'h0, bad});
    axi_rd(OFF_FILL_ADDR_LO);
    chk(rd & (ins ? 32'hFFFF_FFE0 : 32'hFFFF_FFFC),
        {a[31:5], ins ? 3'h0 : a[4:2], 2'h0});
    axi_rd(OFF_FILL_ADDR_HI);
    chk(rd, {30'h0, a[33:32]});
    axi_rd(OFF_DCACHE_STAT);
    chk(rd, ins ? RESET_WORD :
        {23'h0, ld_fp, ld_int, ld_lock, ld_long, ld_dest});
    axi_rd(OFF_TAG);
    chk(rd, ext_en ? tag : 32'hA5A5_0F0F);
  endtask
  // ======
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ewv, rq, rb, fv, fi} = '0;
    {awaddr, araddr, wdata, ewd, fd, fp, pa} = '0;
    wstrb = 4'hF;
    fqw = 2'h2;
    ext_en = 1'b1;
    chk_on = 1'b1;
    tag = 32'hA5A5_0F0F;
    {ld_dest, ld_long, ld_lock, ld_int, ld_fp} = {5'h0B, 4'hA};
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(OFF_CTRL);
    chk(rd, CTRL_RESET);
    axi_rd(8'h30);
    chk({rd[29:0], rsp}, {30'h0, RESP_SLVERR});
    for (int k = 0; k < 2; k++) begin
      @(posedge aclk);
      ewv <= 1'b1;
      ewd <= k ? 32'h0000_0003 : 32'h0000_0007;
      @(posedge aclk);
      ewv <= 1'b0;
      #1;
      chk(mwd, ewd);
      chk({30'h0, mwv, mwp}, {30'h0, 1'b1, ^ewd});
    end
    host_rd(1'b0);
    host_rd(1'b1);
    axi_rd(OFF_NMI_CSR);
    chk(rd, 32'h0000_0001 << NMI_PARITY_BIT);
    axi_rd(OFF_IRQ_STAT);
    chk(rd, 32'h0000_0001 << IRQ_HOST_PAR);
    chk({31'h0, irq}, 32'h0000_0000);
    axi_wr(OFF_IRQ_EN, 32'h0000_0003);
    chk({30'h0, wsp}, {30'h0, RESP_OKAY});
    chk({31'h0, irq}, 32'h0000_0001);
    axi_wr(OFF_IRQ_CLR, 32'h0000_0001);
    axi_wr(OFF_NMI_CSR, 32'h0000_0080);
    repeat (2) @(posedge aclk);
    #1;
    chk({30'h0, nmi, irq}, 32'h0000_0000);
    do_fill(1'b1, 8'h04, 32'hC123_4567);
    chk_capture(1'b1, 8'h04, 32'hC123_4567);
    chk({31'h0, irq}, 32'h0000_0001);
    axi_rd(OFF_ERR_ADDR);
    sv_ad = rd;
    axi_rd(OFF_BUS_STAT);
    sv_st = rd;
    do_fill(1'b0, 8'h00, 32'h1234_5678);
    axi_rd(OFF_ERR_ADDR);
    chk(rd, sv_ad);
    axi_rd(OFF_BUS_STAT);
    chk({25'h0, rd[6:0]}, {25'h0, sv_st[6:0]});
    axi_wr(OFF_BUS_STAT, 32'h0000_0100);
    axi_wr(OFF_IRQ_CLR, 32'h0000_0002);
    chk({31'h0, irq}, 32'h0000_0000);
    @(posedge aclk);
    tag <= 32'h5A5A_F0F0;
    ext_en <= 1'b0;
    do_fill(1'b0, 8'h81, 32'h8765_432B);
    chk_capture(1'b0, 8'h81, 32'h8765_432B);
    axi_wr(OFF_IRQ_STAT, 32'h0000_0000);
    chk({30'h0, wsp}, {30'h0, RESP_SLVERR});
    chk_on = 1'b0;
    axi_wr(OFF_CTRL, 32'h0000_0000);
    chk({30'h0, wsp}, {30'h0, RESP_OKAY});
    host_rd(1'b1);
    complete_run;
  end
endmodule
